// ==== verilog/vsc_cfg.svh ====
// constants for the oscillator subsystem configuration bank
// assumes a single 100 MHz system clock shared by both ends
`ifndef VSC_CFG_SVH
`define VSC_CFG_SVH
`define VSC_SUBSYS_ID_OSC     3'h0
`define VSC_ID_LSB            0
`define VSC_ADDR_LSB          3
`define VSC_DATA_LSB          7
`define VSC_WORD_W            16
`define VSC_ADDR_ENABLES      4'h1
`define VSC_ADDR_DIVIDER      4'h2
`define VSC_ADDR_CONFIG       4'h3
`define VSC_RST_ENABLES       9'h1bf
`define VSC_RST_DIVIDER       9'h001
`define VSC_RST_CONFIG        9'h092
`define VSC_DIV_MAX           6'h3e
`define VSC_PRIO_POWER        2'h1
`define VSC_PRIO_PERF         2'h3
`define VSC_APB_CMD           12'h000
`define VSC_APB_STATUS        12'h004
`define VSC_APB_MON           12'h008
`endif

// ==== verilog/vsc_pkg.sv ====
// types shared by the oscillator subsystem ends
// assumes vsc_cfg.svh for the numeric constants
`default_nettype none
package vsc_pkg;
  typedef enum logic [1:0] {
    VSC_MUTE_DIV0  = 2'h0,
    VSC_MUTE_CAL   = 2'h1,
    VSC_MUTE_LOCK  = 2'h2,
    VSC_MUTE_ALWAYS = 2'h3
  } vsc_mute_type;
  typedef enum logic [1:0] {
    VSC_HOST_IDLE = 2'h0,
    VSC_HOST_SEND = 2'h1,
    VSC_HOST_DONE = 2'h3
  } vsc_host_state_type;
endpackage
`default_nettype wire

// ==== verilog/vsc_if.sv ====
// link between the host writer and the oscillator subsystem bank
// assumes both ends run on the same system clock
`timescale 1ns/10ps
`default_nettype none
interface vsc_if;
  logic        wr_valid;
  logic [15:0] wr_word;
  modport host   (output wr_valid, output wr_word);
  modport device (input wr_valid, input wr_word);
endinterface
`default_nettype wire

// ==== verilog/vsc_device.sv ====
// oscillator subsystem configuration bank, device end
// assumes a finished indirect-access write arrives as one wr_valid pulse
//
// Design decision made at the host end, not here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "vsc_cfg.svh"
module vsc_device (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  // link
  vsc_if.device           link,
  // status from the analog side, asynchronous
  input  wire logic       band_search_busy_in,
  input  wire logic       pll_locked_in,
  input  wire logic       general_purpose_output_in,
  // controls toward the analog side
  output logic            subsystem_on_out,
  output logic            oscillator_on_out,
  output logic            feedback_buffer_on_out,
  output logic            output_divider_on_out,
  output logic            output_stage_on_out,
  output logic [5:0]      divide_ratio_out,
  output logic            divider_bypass_out,
  output logic            low_current_out,
  output logic            positive_output_pin_en_out,
  output logic            negative_output_pin_en_out,
  output logic            internal_termination_out,
  output logic            raised_termination_out,
  output logic            mute_out,
  output logic            calibration_busy_out,
  output logic            lock_status_out
);
  logic [8:0] enables_reg;
  logic [8:0] divider_reg;
  logic [8:0] config_reg;
  logic [2:0] busy_sync;
  logic [2:0] lock_sync;
  logic [2:0] gpo_sync;
  logic       busy_q;
  logic       lock_q;
  logic       gpo_q;
  logic [8:0] wr_data;
  logic [3:0] wr_addr;
  logic       wr_hit;
  vsc_pkg::vsc_mute_type mute_mode;

  function automatic logic [5:0] vsc_ratio(input logic [5:0] raw);
    logic [5:0] r;
    r = raw;
    if (raw > `VSC_DIV_MAX) begin
      r = `VSC_DIV_MAX;
    end else if (raw > 6'h1) begin
      r = {raw[5:1], 1'b0};
    end
    return r;
  endfunction

  assign wr_data = link.wr_word[`VSC_DATA_LSB +: 9];
  assign wr_addr = link.wr_word[`VSC_ADDR_LSB +: 4];
  assign wr_hit  = link.wr_valid && (link.wr_word[`VSC_ID_LSB +: 3] == `VSC_SUBSYS_ID_OSC);

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enables_reg <= `VSC_RST_ENABLES;
      divider_reg <= `VSC_RST_DIVIDER;
      config_reg  <= `VSC_RST_CONFIG;
    end else if (wr_hit) begin
      case (wr_addr)
        `VSC_ADDR_ENABLES: begin
          enables_reg <= wr_data;
        end
        `VSC_ADDR_DIVIDER: begin
          divider_reg <= wr_data;
        end
        `VSC_ADDR_CONFIG: begin
          config_reg <= wr_data;
        end
        default: begin
        end
      endcase
    end
  end

  // status pins cross in, second and third must agree
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_sync <= 3'h0;
      lock_sync <= 3'h0;
      gpo_sync  <= 3'h0;
      busy_q    <= 1'b0;
      lock_q    <= 1'b0;
      gpo_q     <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[1:0], band_search_busy_in};
      lock_sync <= {lock_sync[1:0], pll_locked_in};
      gpo_sync  <= {gpo_sync[1:0], general_purpose_output_in};
      if (busy_sync[1] == busy_sync[2]) begin
        busy_q <= busy_sync[2];
      end
      if (lock_sync[1] == lock_sync[2]) begin
        lock_q <= lock_sync[2];
      end
      if (gpo_sync[1] == gpo_sync[2]) begin
        gpo_q <= gpo_sync[2];
      end
    end
  end

  assign mute_mode = vsc_pkg::vsc_mute_type'(config_reg[8:7]);

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      subsystem_on_out           <= 1'b1;
      oscillator_on_out          <= 1'b1;
      feedback_buffer_on_out     <= 1'b1;
      output_divider_on_out      <= 1'b1;
      output_stage_on_out        <= 1'b1;
      divide_ratio_out           <= 6'h1;
      divider_bypass_out         <= 1'b1;
      low_current_out            <= 1'b1;
      positive_output_pin_en_out <= 1'b0;
      negative_output_pin_en_out <= 1'b0;
      internal_termination_out   <= 1'b1;
      raised_termination_out     <= 1'b0;
      mute_out                   <= 1'b0;
      calibration_busy_out       <= 1'b0;
      lock_status_out            <= 1'b0;
    end else begin
      subsystem_on_out       <= enables_reg[0];
      oscillator_on_out      <= enables_reg[0] & enables_reg[1];
      feedback_buffer_on_out <= enables_reg[0] & enables_reg[2];
      output_divider_on_out  <= enables_reg[0] & enables_reg[3];
      output_stage_on_out    <= enables_reg[0] & enables_reg[3] & enables_reg[5];
      divide_ratio_out   <= vsc_ratio(divider_reg[5:0]);
      divider_bypass_out <= (divider_reg[5:0] == 6'h1);
      // priority select, unsupported codes 0 and 2 treated as power
      low_current_out <= (config_reg[1:0] != `VSC_PRIO_PERF);
      positive_output_pin_en_out <= config_reg[2];
      negative_output_pin_en_out <= config_reg[3];
      internal_termination_out <= config_reg[4];
      raised_termination_out <= config_reg[5];
      calibration_busy_out <= busy_q;
      lock_status_out <= lock_q;
      case (mute_mode)
        vsc_pkg::VSC_MUTE_DIV0: begin
          mute_out <= (divider_reg[5:0] == 6'h0);
        end
        vsc_pkg::VSC_MUTE_CAL: begin
          mute_out <= busy_q | (divider_reg[5:0] == 6'h0);
        end
        vsc_pkg::VSC_MUTE_LOCK: begin
          mute_out <= busy_q | ~lock_q | ~gpo_q | (divider_reg[5:0] == 6'h0);
        end
        vsc_pkg::VSC_MUTE_ALWAYS: begin
          mute_out <= 1'b1;
        end
        default: begin
          mute_out <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verilog/vsc_host.sv ====
// host end: apb slave registers that issue indirect-access writes
// assumes apb master on the same clock; link carries one word per pulse
`timescale 1ns/10ps
`default_nettype none
`include "vsc_cfg.svh"
module vsc_host (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic [31:0]      prdata_out,
  output logic             pslverr_out,
  // link
  vsc_if.host              link
);
  vsc_pkg::vsc_host_state_type state;
  logic [15:0] last_word;
  logic [31:0] write_count;
  logic        acc;
  logic        cmd_wr;

  assign acc        = psel_in & penable_in;
  assign pready_out = 1'b1;
  assign pslverr_out = acc & (paddr_in != `VSC_APB_CMD) & (paddr_in != `VSC_APB_STATUS)
                       & (paddr_in != `VSC_APB_MON);
  assign cmd_wr     = acc & pwrite_in & (paddr_in == `VSC_APB_CMD) & (state == vsc_pkg::VSC_HOST_IDLE);

  // software passes a full nine-bit value each write
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state       <= vsc_pkg::VSC_HOST_IDLE;
      link.wr_valid <= 1'b0;
      link.wr_word  <= 16'h0;
      last_word   <= 16'h0;
      write_count <= 32'h0;
    end else begin
      case (state)
        vsc_pkg::VSC_HOST_IDLE: begin
          link.wr_valid <= 1'b0;
          if (cmd_wr) begin
            link.wr_word <= pwdata_in[15:0];
            last_word    <= pwdata_in[15:0];
            state        <= vsc_pkg::VSC_HOST_SEND;
          end
        end
        vsc_pkg::VSC_HOST_SEND: begin
          link.wr_valid <= 1'b1;
          write_count   <= write_count + 32'h1;
          state         <= vsc_pkg::VSC_HOST_DONE;
        end
        vsc_pkg::VSC_HOST_DONE: begin
          link.wr_valid <= 1'b0;
          state         <= vsc_pkg::VSC_HOST_IDLE;
        end
        default: begin
          link.wr_valid <= 1'b0;
          state         <= vsc_pkg::VSC_HOST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_out <= 32'h0;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      case (paddr_in)
        `VSC_APB_CMD: begin
          prdata_out <= {16'h0, last_word};
        end
        `VSC_APB_STATUS: begin
          prdata_out <= {31'h0, (state != vsc_pkg::VSC_HOST_IDLE)};
        end
        `VSC_APB_MON: begin
          prdata_out <= write_count;
        end
        default: begin
          prdata_out <= 32'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== testbench/vsc_chk.sv ====
// link and output checker for the oscillator subsystem bank
// assumes instantiation beside the link inside the bench
`timescale 1ns/10ps
`default_nettype none
module vsc_chk (
  // clock, reset, link
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic        wr_valid,
  input  wire logic [15:0] wr_word,
  // device outputs
  input  wire logic        subsystem_on_out,
  input  wire logic        output_divider_on_out,
  input  wire logic        output_stage_on_out,
  input  wire logic [5:0]  divide_ratio_out,
  input  wire logic        divider_bypass_out,
  input  wire logic        positive_output_pin_en_out,
  input  wire logic        mute_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_enables_write; wr_valid && wr_word[6:0] == 7'h08; endsequence
  sequence s_config_write; wr_valid && wr_word[6:0] == 7'h18; endsequence
  a_single_pulse: assert property (wr_valid |=> !wr_valid)
    else $error("link strobe longer than one cycle");
  a_master_off: assert property (s_enables_write ##0 !wr_word[7] |-> ##2 !subsystem_on_out)
    else $error("master enable clear ignored");
  a_stage_gate: assert property (output_stage_on_out |-> output_divider_on_out && subsystem_on_out)
    else $error("output stage on without its gates");
  a_div_even: assert property (divide_ratio_out > 6'h01 |-> !divide_ratio_out[0] && divide_ratio_out <= 6'h3e)
    else $error("divide ratio odd or above limit");
  a_bypass_one: assert property (divider_bypass_out == (divide_ratio_out == 6'h01))
    else $error("bypass does not match ratio one");
  a_pos_pin: assert property (s_config_write |-> ##2 positive_output_pin_en_out == $past(wr_word[9], 2))
    else $error("positive pin enable not taken from data bit two");
  a_mute_always: assert property (s_config_write ##0 wr_word[15:14] == 2'h3 |-> ##[1:5] mute_out)
    else $error("mute mode three did not mute");
  // quiet link means frozen master enable and divide ratio; catches stray updates
  a_quiet_hold: assert property (!wr_valid [*2] |=> $stable(subsystem_on_out) && $stable(divide_ratio_out))
    else $error("control changed without a link write");
endmodule
`default_nettype wire

// ==== testbench/vsc_tb.sv ====
// self-checking bench: apb into host, host linked to device
// assumes one 100 MHz clock; bench drives apb and analog status
`timescale 1ns/10ps
`default_nettype none
`include "vsc_cfg.svh"
module vsc_subsystem_config_regs_tb;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, err, band_search_busy_in = 1'b0, pll_locked_in = 1'b1, general_purpose_output_in = 1'b1;
  logic subsystem_on_out, oscillator_on_out, feedback_buffer_on_out, output_divider_on_out, output_stage_on_out;
  logic [5:0] divide_ratio_out;
  logic divider_bypass_out, low_current_out, positive_output_pin_en_out, negative_output_pin_en_out;
  logic internal_termination_out, raised_termination_out, mute_out, calibration_busy_out, lock_status_out;
  logic [4:0] ens, cfgv;
  int err_total = 0, checked = 0;
  assign ens = {subsystem_on_out, oscillator_on_out, feedback_buffer_on_out, output_divider_on_out, output_stage_on_out};
  assign cfgv = {low_current_out, positive_output_pin_en_out, negative_output_pin_en_out, internal_termination_out,
                 raised_termination_out};
  vsc_if link ();
  vsc_host vsc_host_inst (.clk_sys_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
                          .pready_out, .prdata_out, .pslverr_out, .link(link.host));
  vsc_device vsc_device_inst (.clk_sys_in, .rstn_in, .link(link.device), .band_search_busy_in, .pll_locked_in,
    .general_purpose_output_in, .subsystem_on_out, .oscillator_on_out, .feedback_buffer_on_out,
    .output_divider_on_out, .output_stage_on_out, .divide_ratio_out, .divider_bypass_out, .low_current_out,
    .positive_output_pin_en_out, .negative_output_pin_en_out, .internal_termination_out, .raised_termination_out,
    .mute_out, .calibration_busy_out, .lock_status_out);
  vsc_chk vsc_chk_inst (.clk_sys_in, .rstn_in, .wr_valid(link.wr_valid), .wr_word(link.wr_word), .subsystem_on_out,
    .output_divider_on_out, .output_stage_on_out, .divide_ratio_out, .divider_bypass_out,
    .positive_output_pin_en_out, .mute_out);
  always #5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t bus word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1) @(posedge clk_sys_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // busy host drops commands, so poll status before going on
  task automatic raw(input logic [15:0] w);
    apb(`VSC_APB_CMD, 1'b1, {16'h0, w});
    do apb(`VSC_APB_STATUS, 1'b0, 32'h0); while (rd[0] !== 1'b0);
    repeat (8) @(posedge clk_sys_in);
  endtask
  task automatic send(input logic [3:0] a, input logic [8:0] d);
    raw({d, a, 3'h0});
  endtask
  task automatic t_reset();
    chk({4'h0, ens}, 9'h01f); // enables default on
    chk({2'h0, divider_bypass_out, divide_ratio_out}, 9'h041); // ratio one
    chk({4'h0, cfgv}, 9'h012); // config defaults
  endtask
  task automatic t_enables();
    send(`VSC_ADDR_ENABLES, 9'h1df);
    chk({4'h0, ens}, 9'h01e); // stage alone off
    send(`VSC_ADDR_ENABLES, 9'h1f7);
    chk({4'h0, ens}, 9'h01c); // divider and stage off
    send(`VSC_ADDR_ENABLES, 9'h1b9);
    chk({4'h0, ens}, 9'h013); // oscillator and buffer off alone
    send(`VSC_ADDR_ENABLES, 9'h1af);
    chk({4'h0, ens}, 9'h01f); // spare bit ignored
    send(`VSC_ADDR_ENABLES, 9'h1be);
    chk({4'h0, ens}, 9'h000); // master off
    send(`VSC_ADDR_ENABLES, `VSC_RST_ENABLES);
    chk({4'h0, ens}, 9'h01f); // full word restores
  endtask
  task automatic t_divide();
    int e;
    for (int i = 0; i < 64; i++) begin
      send(`VSC_ADDR_DIVIDER, 9'(i));
      e = (i > 62) ? 62 : (i > 1) ? (i & 62) : i;
      chk({2'h0, divider_bypass_out, divide_ratio_out}, {2'h0, i == 1, 6'(e)}); // divide table
    end
  endtask
  task automatic t_config();
    send(`VSC_ADDR_CONFIG, 9'h03d);
    chk({4'h0, cfgv}, 9'h01f); // low current, pins on
    send(`VSC_ADDR_CONFIG, 9'h003);
    chk({4'h0, cfgv}, 9'h000); // performance, external termination
  endtask
  task automatic t_mute();
    logic b, l, g;
    send(`VSC_ADDR_DIVIDER, 9'h000);
    chk({8'h0, mute_out}, 9'h001); // divide zero mutes
    send(`VSC_ADDR_DIVIDER, 9'h002);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 8; s++) begin
        b = s[0];
        l = !s[1];
        g = !s[2];
        band_search_busy_in <= b;
        pll_locked_in <= l;
        general_purpose_output_in <= g;
        send(`VSC_ADDR_CONFIG, {2'(m), 7'h1d});
        chk({6'h0, calibration_busy_out, lock_status_out, mute_out},
            {6'h0, b, l, m == 3 || (m != 0 && b) || (m == 2 && !(l && g))});
      end
    end
  endtask
  task automatic t_refuse();
    logic [31:0] base;
    apb(`VSC_APB_MON, 1'b0, 32'h0);
    base = rd;
    raw({9'h000, `VSC_ADDR_ENABLES, 3'h1});
    raw({9'h000, 4'h4, 3'h0});
    chk({4'h0, ens}, 9'h01f); // foreign id and address ignored
    chk({3'h0, divide_ratio_out}, 9'h002); // divider untouched
    apb(`VSC_APB_CMD, 1'b0, 32'h0);
    chk_word(rd, 32'h20); // last indirect word reads back
    apb(`VSC_APB_MON, 1'b0, 32'h0);
    chk_word(rd - base, 32'h2); // every command reaches the link
    chk({8'h0, err}, 9'h000); // mapped address accepted
    apb(12'h00c, 1'b1, 32'h0);
    chk({8'h0, err}, 9'h001); // unmapped refused
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    // 108 link writes of under 30 cycles each, with wide margin
    repeat (20000) @(posedge clk_sys_in);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    t_reset();
    t_enables();
    t_divide();
    t_config();
    t_mute();
    t_refuse();
    complete_run();
  end
endmodule
`default_nettype wire
